// File: parallel_program_port.sv
`timescale 1ns/1ps
module parallel_program_port #(
   parameter int         FLASH_AW     = 14,
   parameter int         PAGE_BITS    = 6,
   parameter int         EE_AW        = 10,
   parameter int         EE_PAGE_BITS = 2,
   parameter int         ERASE_CYCLES = parallel_program_port_pkg::ERASE_CYCLES,
   parameter int         PROG_CYCLES  = parallel_program_port_pkg::PROG_CYCLES,
   parameter logic [7:0] SIG_BYTE0    = 8'h5a, // arbitrary value
   parameter logic [7:0] SIG_BYTE1    = 8'h3c, // arbitrary value
   parameter logic [7:0] SIG_BYTE2    = 8'h21, // arbitrary value
   parameter logic [7:0] CAL_BYTE     = 8'h80  // arbitrary value
) (
   input  wire logic                              ref_clk,
   input  wire logic                              sys_rst,
   input  wire logic                              link_clk,
   input  wire parallel_program_port_pkg::pin_in_s pins,
   output logic                                   op_done_flag_q,
   output logic [7:0]                             data_out_q,
   output logic                                   data_oe_q,
   output logic                                   prog_mode_q
);
   localparam int FLASH_WORDS = 1 << FLASH_AW;
   localparam int PAGE_WORDS  = 1 << PAGE_BITS;
   localparam int EE_BYTES    = 1 << EE_AW;
   localparam int EE_PAGE     = 1 << EE_PAGE_BITS;
   localparam int SW          = (FLASH_AW > EE_AW ? FLASH_AW : EE_AW) + 1;
   localparam int SWEEP_END   = (FLASH_WORDS > EE_BYTES ? FLASH_WORDS : EE_BYTES) - 1;

   initial
   begin
      if (PAGE_BITS < 1 || PAGE_BITS > 8 || FLASH_AW < PAGE_BITS || FLASH_AW > 16)
         $error("parallel_program_port: flash geometry not supported");
      if (EE_PAGE_BITS < 1 || EE_PAGE_BITS > 8 || EE_AW < EE_PAGE_BITS || EE_AW > 16)
         $error("parallel_program_port: eeprom geometry not supported");
   end

   typedef enum {ST_IDLE, ST_ERASE, ST_PROG_FLASH, ST_PROG_EE, ST_WAIT} op_state_e;

   parallel_program_port_pkg::pin_in_s pin_s;
   parallel_program_port_pkg::pin_in_s prev_q;
   logic                  link_rst;
   logic                  done_s;
   logic                  done_tgl;
   logic                  done_prev_q;
   logic                  timer_done_q;
   logic                  start_tgl_q;
   logic                  long_op_q;
   op_state_e             state_q;
   logic [SW-1:0]         sweep_q;
   logic [7:0]            cmd_q;
   logic [15:0]           addr_q;
   logic [7:0]            data_lo_q;
   logic [7:0]            data_hi_q;
   logic [FLASH_AW-PAGE_BITS-1:0] page_q;
   logic [EE_AW-EE_PAGE_BITS-1:0] ee_page_q;
   logic [7:0]            fuse_lo_q;
   logic [7:0]            fuse_hi_q;
   logic [7:0]            fuse_ext_q;
   logic [7:0]            lock_q;
   logic [15:0]           flash_mem [FLASH_WORDS];
   logic [7:0]            ee_mem [EE_BYTES];
   logic [15:0]           pbuf [PAGE_WORDS];
   logic [PAGE_WORDS-1:0] pbuf_vld_q;
   logic [7:0]            ebuf [EE_PAGE];
   logic [EE_PAGE-1:0]    ebuf_vld_q;
   logic                  load_rise;
   logic                  write_fall;
   logic                  latch_rise;
   logic                  busy;
   logic                  sweep_last;
   logic [1:0]            action;
   logic [PAGE_BITS-1:0]  word_in_page_index;
   logic [FLASH_AW-PAGE_BITS-1:0] flash_page_index;
   logic [EE_PAGE_BITS-1:0] eeprom_byte_index;
   logic [FLASH_AW-1:0]   flash_addr;
   logic [EE_AW-1:0]      ee_addr;
   logic [FLASH_AW-1:0]   prog_addr;
   logic [EE_AW-1:0]      ee_prog_addr;
   logic [7:0]            rd_sel;

   // link-side reset comes from the system reset through two flops
   sync_2ff #(.W(1)) u_rst_sync (
      .clk (link_clk),
      .rst (1'b0),
      .d   (sys_rst),
      .q   (link_rst)
   );

   // programmer pins are asynchronous to the link clock
   sync_2ff #(.W($bits(parallel_program_port_pkg::pin_in_s))) u_pin_sync (
      .clk (link_clk),
      .rst (link_rst),
      .d   (pins),
      .q   (pin_s)
   );

   sync_2ff #(.W(1)) u_done_sync (
      .clk (link_clk),
      .rst (link_rst),
      .d   (done_tgl),
      .q   (done_s)
   );

   op_timer #(
      .ERASE_CYCLES (ERASE_CYCLES),
      .PROG_CYCLES  (PROG_CYCLES)
   ) u_timer (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .start_tgl (start_tgl_q),
      .long_op   (long_op_q),
      .done_tgl  (done_tgl)
   );

   // strobe edges seen on synchronised pins
   assign busy       = (state_q != ST_IDLE);
   assign load_rise  = prog_mode_q & ~busy & pin_s.load_strobe & ~prev_q.load_strobe;
   assign write_fall = prog_mode_q & ~busy & ~pin_s.write_strobe_n & prev_q.write_strobe_n;
   assign latch_rise = prog_mode_q & ~busy & pin_s.page_latch_strobe
                       & ~prev_q.page_latch_strobe;
   assign action     = {pin_s.action_code_bit1, pin_s.action_code_bit0};
   assign sweep_last = (sweep_q == SW'(SWEEP_END));

   // address split into word, page and byte indexes
   assign flash_addr         = addr_q[FLASH_AW-1:0];
   assign ee_addr            = addr_q[EE_AW-1:0];
   assign word_in_page_index = addr_q[PAGE_BITS-1:0];
   assign flash_page_index   = addr_q[FLASH_AW-1:PAGE_BITS];
   assign eeprom_byte_index  = addr_q[EE_PAGE_BITS-1:0];
   assign prog_addr          = {page_q, sweep_q[PAGE_BITS-1:0]};
   assign ee_prog_addr       = {ee_page_q, sweep_q[EE_PAGE_BITS-1:0]};

   // entry pattern caught at the high-voltage rise, mode ends at its fall
   always_ff @(posedge link_clk)
   begin
      if (link_rst)
      begin
         prev_q      <= '0;
         prog_mode_q <= 1'b0;
      end
      else
      begin
         prev_q <= pin_s;
         if (pin_s.hv_reset & ~prev_q.hv_reset)
            prog_mode_q <= ({pin_s.page_latch_strobe, pin_s.action_code_bit1,
                             pin_s.action_code_bit0, pin_s.byte_select_lo_hi}
                            == parallel_program_port_pkg::ENTRY_PATTERN);
         else if (~pin_s.hv_reset)
            prog_mode_q <= 1'b0;
      end
   end

   // load pulse actions; command and address persist between operations
   always_ff @(posedge link_clk)
   begin
      if (link_rst)
      begin
         cmd_q     <= parallel_program_port_pkg::CMD_NOP;
         addr_q    <= '0;
         data_lo_q <= '0;
         data_hi_q <= '0;
      end
      else if (load_rise)
      begin
         case (action)
            parallel_program_port_pkg::ACT_ADDR:
               if (pin_s.byte_select_lo_hi)
                  addr_q[15:8] <= pin_s.data;
               else
                  addr_q[7:0] <= pin_s.data;
            parallel_program_port_pkg::ACT_DATA:
               if (pin_s.byte_select_lo_hi)
                  data_hi_q <= pin_s.data;
               else
                  data_lo_q <= pin_s.data;
            parallel_program_port_pkg::ACT_CMD:
               cmd_q <= pin_s.data;
            default:
               cmd_q <= cmd_q;
         endcase
      end
   end

   // flash page buffer, one word per latch pulse
   always_ff @(posedge link_clk)
   begin
      if (latch_rise && pin_s.byte_select_lo_hi
          && cmd_q == parallel_program_port_pkg::CMD_WR_FLASH)
         pbuf[word_in_page_index] <= {data_hi_q, data_lo_q};
   end

   // eeprom page buffer takes the low data byte
   always_ff @(posedge link_clk)
   begin
      if (latch_rise && cmd_q == parallel_program_port_pkg::CMD_WR_EEPROM)
         ebuf[eeprom_byte_index] <= data_lo_q;
   end

   // valid marks keep unloaded buffer words from touching the memory
   always_ff @(posedge link_clk)
   begin
      if (link_rst)
      begin
         pbuf_vld_q <= '0;
         ebuf_vld_q <= '0;
      end
      else if (load_rise && action == parallel_program_port_pkg::ACT_CMD
               && pin_s.data == parallel_program_port_pkg::CMD_NOP)
      begin
         pbuf_vld_q <= '0;
         ebuf_vld_q <= '0;
      end
      else
      begin
         if (state_q == ST_PROG_FLASH && sweep_q == SW'(PAGE_WORDS - 1))
            pbuf_vld_q <= '0;
         else if (latch_rise && pin_s.byte_select_lo_hi
                  && cmd_q == parallel_program_port_pkg::CMD_WR_FLASH)
            pbuf_vld_q[word_in_page_index] <= 1'b1;
         if (state_q == ST_PROG_EE && sweep_q == SW'(EE_PAGE - 1))
            ebuf_vld_q <= '0;
         else if (latch_rise && cmd_q == parallel_program_port_pkg::CMD_WR_EEPROM)
            ebuf_vld_q[eeprom_byte_index] <= 1'b1;
      end
   end

   // operation sequencer: memory sweep on the link side, minimum time on ref side
   always_ff @(posedge link_clk)
   begin
      if (link_rst)
      begin
         state_q      <= ST_IDLE;
         sweep_q      <= '0;
         start_tgl_q  <= 1'b0;
         long_op_q    <= 1'b0;
         page_q       <= '0;
         ee_page_q    <= '0;
         done_prev_q  <= 1'b0;
         timer_done_q <= 1'b0;
      end
      else
      begin
         done_prev_q <= done_s;
         case (state_q)
            ST_IDLE:
            begin
               sweep_q      <= '0;
               timer_done_q <= 1'b0;
               if (write_fall)
               begin
                  case (cmd_q)
                     parallel_program_port_pkg::CMD_CHIP_ERASE:
                     begin
                        state_q     <= ST_ERASE;
                        long_op_q   <= 1'b1;
                        start_tgl_q <= ~start_tgl_q;
                     end
                     parallel_program_port_pkg::CMD_WR_FLASH:
                     begin
                        state_q     <= ST_PROG_FLASH;
                        page_q      <= flash_page_index;
                        long_op_q   <= 1'b0;
                        start_tgl_q <= ~start_tgl_q;
                     end
                     parallel_program_port_pkg::CMD_WR_EEPROM:
                        if (!pin_s.byte_select_lo_hi)
                        begin
                           state_q     <= ST_PROG_EE;
                           ee_page_q   <= ee_addr[EE_AW-1:EE_PAGE_BITS];
                           long_op_q   <= 1'b0;
                           start_tgl_q <= ~start_tgl_q;
                        end
                     parallel_program_port_pkg::CMD_WR_FUSE,
                     parallel_program_port_pkg::CMD_WR_LOCK:
                     begin
                        state_q     <= ST_WAIT;
                        long_op_q   <= 1'b0;
                        start_tgl_q <= ~start_tgl_q;
                     end
                     default:
                        state_q <= ST_IDLE;
                  endcase
               end
            end
            ST_ERASE:
            begin
               sweep_q <= sweep_q + SW'(1);
               if (sweep_last)
                  state_q <= ST_WAIT;
            end
            ST_PROG_FLASH:
            begin
               sweep_q <= sweep_q + SW'(1);
               if (sweep_q == SW'(PAGE_WORDS - 1))
                  state_q <= ST_WAIT;
            end
            ST_PROG_EE:
            begin
               sweep_q <= sweep_q + SW'(1);
               if (sweep_q == SW'(EE_PAGE - 1))
                  state_q <= ST_WAIT;
            end
            ST_WAIT:
               if (timer_done_q || (done_s != done_prev_q))
                  state_q <= ST_IDLE;
            default:
               state_q <= ST_IDLE;
         endcase
         // timer may finish while the sweep still runs; keep the news
         if (state_q != ST_IDLE && done_s != done_prev_q)
            timer_done_q <= 1'b1;
      end
   end

   // flash array: erase sweep or whole-page copy
   always_ff @(posedge link_clk)
   begin
      if (state_q == ST_ERASE && sweep_q < SW'(FLASH_WORDS))
         flash_mem[sweep_q[FLASH_AW-1:0]] <= parallel_program_port_pkg::ERASED_WORD;
      else if (state_q == ST_PROG_FLASH && pbuf_vld_q[sweep_q[PAGE_BITS-1:0]])
         flash_mem[prog_addr] <= pbuf[sweep_q[PAGE_BITS-1:0]];
   end

   // eeprom array, spared by erase when the keep fuse is programmed
   always_ff @(posedge link_clk)
   begin
      if (state_q == ST_ERASE && sweep_q < SW'(EE_BYTES)
          && fuse_hi_q[parallel_program_port_pkg::KEEP_EE_BIT])
         ee_mem[sweep_q[EE_AW-1:0]] <= parallel_program_port_pkg::ERASED_BYTE;
      else if (state_q == ST_PROG_EE && ebuf_vld_q[sweep_q[EE_PAGE_BITS-1:0]])
         ee_mem[ee_prog_addr] <= ebuf[sweep_q[EE_PAGE_BITS-1:0]];
   end

   // fuses survive erase; locks only clear after the flash sweep ends
   always_ff @(posedge link_clk)
   begin
      if (link_rst)
      begin
         fuse_lo_q  <= parallel_program_port_pkg::FUSE_LO_RST;
         fuse_hi_q  <= parallel_program_port_pkg::FUSE_HI_RST;
         fuse_ext_q <= parallel_program_port_pkg::FUSE_EXT_RST;
         lock_q     <= parallel_program_port_pkg::LOCK_RST;
      end
      else if (state_q == ST_ERASE && sweep_last)
         lock_q <= parallel_program_port_pkg::LOCK_RST;
      else if (write_fall && cmd_q == parallel_program_port_pkg::CMD_WR_LOCK)
         lock_q <= lock_q & data_lo_q; // only programs, never erases
      else if (write_fall && cmd_q == parallel_program_port_pkg::CMD_WR_FUSE && lock_q[0])
      begin
         case ({pin_s.byte_select_extra, pin_s.byte_select_lo_hi})
            2'h0:    fuse_lo_q  <= data_lo_q;
            2'h1:    fuse_hi_q  <= data_lo_q;
            2'h2:    fuse_ext_q <= data_lo_q;
            default: fuse_lo_q  <= fuse_lo_q;
         endcase
      end
   end

   // read data selection by command and byte selects
   always_comb
   begin
      rd_sel = 8'h00;
      case (cmd_q)
         parallel_program_port_pkg::CMD_RD_FLASH:
            rd_sel = pin_s.byte_select_lo_hi ? flash_mem[flash_addr][15:8]
                                             : flash_mem[flash_addr][7:0];
         parallel_program_port_pkg::CMD_RD_EEPROM:
            rd_sel = ee_mem[ee_addr];
         parallel_program_port_pkg::CMD_RD_FUSE:
            case ({pin_s.byte_select_extra, pin_s.byte_select_lo_hi})
               2'h0:    rd_sel = fuse_lo_q;
               2'h3:    rd_sel = fuse_hi_q;
               2'h2:    rd_sel = fuse_ext_q;
               default: rd_sel = lock_q;
            endcase
         parallel_program_port_pkg::CMD_RD_SIG:
            if (pin_s.byte_select_lo_hi)
               rd_sel = CAL_BYTE;
            else if (addr_q[7:0] == 8'h00)
               rd_sel = SIG_BYTE0;
            else if (addr_q[7:0] == 8'h01)
               rd_sel = SIG_BYTE1;
            else if (addr_q[7:0] == 8'h02)
               rd_sel = SIG_BYTE2;
            else
               rd_sel = 8'h00;
         default:
            rd_sel = 8'h00;
      endcase
   end

   // pin outputs all registered
   always_ff @(posedge link_clk)
   begin
      if (link_rst)
      begin
         op_done_flag_q <= 1'b1;
         data_out_q     <= 8'h00;
         data_oe_q      <= 1'b0;
      end
      else
      begin
         // a write pulse under a read command starts nothing, so no busy blip
         op_done_flag_q <= ~busy;
         data_oe_q      <= prog_mode_q & ~pin_s.out_enable_n;
         data_out_q     <= pin_s.out_enable_n ? 8'h00 : rd_sel;
      end
   end
endmodule

// File: parallel_program_port_pkg.sv
// Contract
// - ready flag low while erase or programming runs, high when ready.
// - data bus driven out only while active-low output enable is asserted.
// - load pulse action by code: 00 address, 01 data, 10 command, 11 idle.
// - first byte select picks low or high byte of address or data.
// - second byte select picks low or second high (extended fuse) byte.
// - page latch pulse with first select high stores data word in buffer.
// - command 1000 0000 is chip erase.
// - command 0001 0000 is flash write with page buffer loading.
// - commands 0100 0000 fuse, 0010 0000 lock, 0001 0001 EEPROM write.
// - commands 0000 0100 fuse/lock, 0000 0010 flash, 0000 0011 EEPROM read.
// - command 0000 1000 reads identification and calibration bytes.
// - loaded command and address are kept across operations.
// - erase clears flash, EEPROM, locks; fuses kept; keep-EEPROM fuse saves EEPROM.
// - lock bits cleared only after program memory erase completes.
// - write pulse after erase command starts erase and drops ready flag.
// - flash data gathered in a page buffer, whole page programmed at once.
// - low address bits pick word in page, upper bits pick the page.
// - EEPROM in pages of 4/8 bytes, low address bits pick byte.
// - write pulse after buffer fill programs page, ready flag low meanwhile.
// - no-operation command clears the internal write control state.
package parallel_program_port_pkg;
   localparam int CLK_PERIOD_NS = 25;
   localparam int ERASE_TIME_US = 9000;
   localparam int PROG_TIME_US  = 4500;
   localparam int ERASE_CYCLES  = ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int PROG_CYCLES   = PROG_TIME_US * 1000 / CLK_PERIOD_NS;

   localparam logic [1:0] ACT_ADDR = 2'h0;
   localparam logic [1:0] ACT_DATA = 2'h1;
   localparam logic [1:0] ACT_CMD  = 2'h2;

   localparam logic [7:0] CMD_NOP        = 8'h00;
   localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
   localparam logic [7:0] CMD_WR_FUSE    = 8'h40;
   localparam logic [7:0] CMD_WR_LOCK    = 8'h20;
   localparam logic [7:0] CMD_WR_FLASH   = 8'h10;
   localparam logic [7:0] CMD_WR_EEPROM  = 8'h11;
   localparam logic [7:0] CMD_RD_SIG     = 8'h08;
   localparam logic [7:0] CMD_RD_FUSE    = 8'h04;
   localparam logic [7:0] CMD_RD_FLASH   = 8'h02;
   localparam logic [7:0] CMD_RD_EEPROM  = 8'h03;

   localparam logic [3:0]  ENTRY_PATTERN = 4'h0;
   localparam logic [7:0]  FUSE_LO_RST   = 8'h62;
   localparam logic [7:0]  FUSE_HI_RST   = 8'hff;
   localparam logic [7:0]  FUSE_EXT_RST  = 8'hff;
   localparam logic [7:0]  LOCK_RST      = 8'hff;
   localparam int          KEEP_EE_BIT   = 3;
   localparam logic [15:0] ERASED_WORD   = 16'hffff;
   localparam logic [7:0]  ERASED_BYTE   = 8'hff;

   typedef struct packed {
      logic       hv_reset;
      logic       out_enable_n;
      logic       write_strobe_n;
      logic       load_strobe;
      logic       page_latch_strobe;
      logic       action_code_bit1;
      logic       action_code_bit0;
      logic       byte_select_lo_hi;
      logic       byte_select_extra;
      logic [7:0] data;
   } pin_in_s;
endpackage

// File: sync_2ff.sv
`timescale 1ns/1ps
module sync_2ff #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta_q <= '0;
         q      <= '0;
      end
      else
      begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

// File: op_timer.sv
`timescale 1ns/1ps
module op_timer #(
   parameter int ERASE_CYCLES = parallel_program_port_pkg::ERASE_CYCLES,
   parameter int PROG_CYCLES  = parallel_program_port_pkg::PROG_CYCLES
) (
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   input  wire logic start_tgl,
   input  wire logic long_op,
   output logic      done_tgl
);
   localparam int CW = $clog2(ERASE_CYCLES + PROG_CYCLES + 1);
   logic [1:0]    in_s;
   logic          start_prev_q;
   logic          arm_q;
   logic [CW-1:0] cnt_q;
   logic          run_q;

   initial
   begin
      if (ERASE_CYCLES < 1 || PROG_CYCLES < 1)
         $error("op_timer: cycle counts must be at least one");
   end

   sync_2ff #(.W(2)) u_sync (
      .clk (ref_clk),
      .rst (sys_rst),
      .d   ({start_tgl, long_op}),
      .q   (in_s)
   );

   // kind is read one cycle after the toggle edge, so it has settled
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         start_prev_q <= 1'b0;
         arm_q        <= 1'b0;
         cnt_q        <= '0;
         run_q        <= 1'b0;
         done_tgl     <= 1'b0;
      end
      else
      begin
         start_prev_q <= in_s[1];
         arm_q        <= in_s[1] ^ start_prev_q;
         if (arm_q)
         begin
            cnt_q <= in_s[0] ? CW'(ERASE_CYCLES) : CW'(PROG_CYCLES);
            run_q <= 1'b1;
         end
         else if (run_q)
         begin
            if (cnt_q <= CW'(1))
            begin
               run_q    <= 1'b0;
               done_tgl <= ~done_tgl;
            end
            cnt_q <= cnt_q - CW'(1);
         end
      end
   end
endmodule

// File: port_props.sv
`timescale 1ns/1ps
module port_props (
   input wire logic                               sys_rst,
   input wire logic                               link_clk,
   input wire parallel_program_port_pkg::pin_in_s pins,
   input wire logic                               op_done_flag_q,
   input wire logic [7:0]                         data_out_q,
   input wire logic                               data_oe_q,
   input wire logic                               prog_mode_q
);
   logic [3:0]  entry_pins;
   logic [15:0] busy_len_q;
   // pins that qualify entry
   assign entry_pins = {pins.page_latch_strobe, pins.action_code_bit1, pins.action_code_bit0,
                        pins.byte_select_lo_hi};
   // busy run length; erase is the longest job, so one bound covers all
   always_ff @(posedge link_clk)
   begin
      busy_len_q <= (sys_rst || op_done_flag_q) ? 16'h0000 : busy_len_q + 16'h0001;
   end
   default clocking @(posedge link_clk);
   endclocking
   default disable iff (sys_rst);
   oe_off_a: assert property (pins.out_enable_n [*5] |-> !data_oe_q && !data_out_q)
      else $error("bus driven with enable off");
   oe_on_a: assert property ((prog_mode_q && !pins.out_enable_n) [*5] |-> data_oe_q)
      else $error("bus not driven on read");
   oe_mode_a: assert property (data_oe_q |-> prog_mode_q)
      else $error("bus driven outside mode");
   busy_start_a: assert property ($fell(op_done_flag_q) |-> !$past(pins.write_strobe_n, 2))
      else $error("busy without write pulse");
   busy_min_a: assert property ($fell(op_done_flag_q) |=> !op_done_flag_q [*3])
      else $error("busy too short");
   busy_max_a: assert property (busy_len_q < 16'h1000)
      else $error("busy never ends");
   mode_entry_a: assert property ($rose(prog_mode_q) |-> pins.hv_reset && $past(entry_pins, 3) == 4'h0)
      else $error("mode entered on bad pattern");
   mode_exit_a: assert property (!pins.hv_reset [*5] |-> !prog_mode_q)
      else $error("mode held without high voltage");
endmodule

// File: prog_model.sv
`timescale 1ns/1ps
module prog_model (
   input  wire logic                           link_clk,
   input  wire logic                           op_done_flag_q,
   input  wire logic                           data_oe_q,
   input  wire logic [7:0]                     data_out_q,
   output parallel_program_port_pkg::pin_in_s pins
);
   parallel_program_port_pkg::pin_in_s p_q = '{out_enable_n: 1'b1, write_strobe_n: 1'b1, default: '0};
   // released bus shows the inverse of our last drive, never a held value
   always_comb
   begin
      pins      = p_q;
      pins.data = data_oe_q ? data_out_q : (p_q.out_enable_n ? p_q.data : ~p_q.data);
   end
   task automatic tick(input int n);
      repeat (n) @(posedge link_clk);
   endtask
   // strobe set {wr, load, latch}; 6 cycles per level beats the pin sync depth
   task automatic pulse(input logic [2:0] s, output logic rdy);
      tick(3);
      {p_q.write_strobe_n, p_q.load_strobe, p_q.page_latch_strobe} <= s ^ 3'b100;
      tick(6);
      rdy = op_done_flag_q;
      {p_q.write_strobe_n, p_q.load_strobe, p_q.page_latch_strobe} <= 3'b100;
      for (int i = 0; i < 9000 && !op_done_flag_q; i++) // no command while busy
         tick(1);
      tick(6);
   endtask
   task automatic load(input logic [1:0] act, input logic [1:0] bs, input logic [7:0] d);
      logic r;
      tick(1);
      {p_q.action_code_bit1, p_q.action_code_bit0, p_q.byte_select_lo_hi, p_q.byte_select_extra,
       p_q.data} <= {act, bs, d};
      pulse(3'b010, r);
   endtask
   task automatic rd(input logic [1:0] bs, output logic [7:0] v);
      tick(1);
      {p_q.out_enable_n, p_q.byte_select_lo_hi, p_q.byte_select_extra} <= {1'b0, bs};
      tick(6);
      v = pins.data;
      p_q.out_enable_n <= 1'b1;
      tick(6);
   endtask
   // pattern pins sit at 0 from time zero
   task automatic enter();
      tick(5);
      p_q.hv_reset <= 1'b1;
      tick(30);
   endtask
endmodule

// File: parallel_program_port_tb.sv
`timescale 1ns/1ps
module parallel_program_port_tb;
   localparam logic [7:0] SIG0 = 8'h5a; // arbitrary value
   localparam logic [7:0] CAL  = 8'h80; // arbitrary value
   logic                               ref_clk = 1'b0;
   logic                               link_clk = 1'b0;
   logic                               sys_rst = 1'b1;
   parallel_program_port_pkg::pin_in_s pins;
   logic                               op_done_flag_q;
   logic [7:0]                         data_out_q;
   logic                               data_oe_q;
   logic                               prog_mode_q;
   logic                               r;
   logic [7:0]                         v;
   int                                 n_fail = 0;
   int                                 n_checks = 0;
   // link clock period is no multiple of the system one
   always #12.5 ref_clk = ~ref_clk;
   always #32 link_clk = ~link_clk;
   parallel_program_port #(.FLASH_AW(10), .ERASE_CYCLES(20), .PROG_CYCLES(10), .SIG_BYTE0(SIG0),
      .CAL_BYTE(CAL)) parallel_program_port_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .link_clk(link_clk), .pins(pins), .op_done_flag_q(op_done_flag_q),
      .data_out_q(data_out_q), .data_oe_q(data_oe_q), .prog_mode_q(prog_mode_q));
   prog_model pgm (.link_clk(link_clk), .op_done_flag_q(op_done_flag_q), .data_oe_q(data_oe_q),
      .data_out_q(data_out_q), .pins(pins));
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rdchk(input string what, input logic [1:0] bs, input logic [7:0] exp);
      pgm.rd(bs, v);
      chk(what, exp, v);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // erase, page write and readback, eeprom, id and fuse reads
   initial
   begin
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'b0;
      pgm.enter();
      chk("mode", 8'h01, prog_mode_q);
      pgm.load(2'h2, 2'b00, 8'h80);
      pgm.pulse(3'b100, r);
      chk("erase busy", 8'h00, r);
      chk("erase ready", 8'h01, op_done_flag_q);
      $display("erase test done");
      pgm.load(2'h2, 2'b00, 8'h10);
      for (int i = 0; i < 2; i++)
      begin
         pgm.load(2'h0, 2'b00, 8'h42 + 8'(i));
         pgm.load(2'h1, 2'b00, 8'hc0 + 8'(i));
         pgm.load(2'h1, 2'b10, 8'h35);
         pgm.pulse(3'b001, r);
      end
      pgm.load(2'h0, 2'b10, 8'h01);
      pgm.pulse(3'b100, r);
      chk("page busy", 8'h00, r);
      pgm.load(2'h2, 2'b00, 8'h02);
      for (int i = 0; i < 3; i++)
      begin
         pgm.load(2'h0, 2'b00, 8'h42 + 8'(i));
         rdchk("flash lo", 2'b00, i < 2 ? 8'hc0 + 8'(i) : 8'hff);
         rdchk("flash hi", 2'b10, i < 2 ? 8'h35 : 8'hff);
      end
      pgm.load(2'h3, 2'b00, 8'h42);
      rdchk("idle action", 2'b00, 8'hff);
      $display("flash test done");
      pgm.load(2'h2, 2'b00, 8'h11);
      pgm.load(2'h0, 2'b10, 8'h00);
      pgm.load(2'h0, 2'b00, 8'h05);
      pgm.load(2'h1, 2'b00, 8'h96);
      pgm.pulse(3'b001, r);
      pgm.pulse(3'b100, r);
      chk("eeprom busy", 8'h00, r);
      pgm.load(2'h2, 2'b00, 8'h03);
      rdchk("eeprom", 2'b00, 8'h96);
      $display("eeprom test done");
      pgm.load(2'h2, 2'b00, 8'h08);
      pgm.load(2'h0, 2'b00, 8'h00);
      rdchk("sig", 2'b00, SIG0);
      rdchk("cal", 2'b10, CAL);
      pgm.load(2'h2, 2'b00, 8'h04);
      rdchk("fuse lo", 2'b00, parallel_program_port_pkg::FUSE_LO_RST);
      rdchk("fuse hi", 2'b11, parallel_program_port_pkg::FUSE_HI_RST);
      rdchk("fuse ext", 2'b01, parallel_program_port_pkg::FUSE_EXT_RST);
      rdchk("lock", 2'b10, parallel_program_port_pkg::ERASED_BYTE);
      $display("id test done");
      end_of_test();
   end
   // the whole sequence needs well under 1 ms
   initial
   begin
      repeat (40000) @(posedge ref_clk);
      n_fail++;
      end_of_test();
   end
endmodule
bind parallel_program_port port_props port_props_inst (.sys_rst(sys_rst), .link_clk(link_clk),
   .pins(pins), .op_done_flag_q(op_done_flag_q), .data_out_q(data_out_q),
   .data_oe_q(data_oe_q), .prog_mode_q(prog_mode_q));
